// *** vgs_pkg.sv ***
/*
  package for the general status and configuration register bank:
  port addresses, field positions, reset values and bus structs.
  assumes a 16-bit vga i/o address space with byte-wide data.
*/
package vgs_pkg;
  // i/o port addresses
  localparam logic [15:0] VGS_FC_WR_MONO_A  = 16'h03ba;
  localparam logic [15:0] VGS_FC_WR_COL_A   = 16'h03da;
  localparam logic [15:0] VGS_MO_WR_A       = 16'h03c2;
  localparam logic [15:0] VGS_BASE_RD_A     = 16'h03c3;
  localparam logic [15:0] VGS_FC_RD_A       = 16'h03ca;
  localparam logic [15:0] VGS_MO_RD_A       = 16'h03cc;
  // misc output field positions
  localparam int VGS_MO_COLOUR_B = 0;
  localparam int VGS_MO_RAM_EN_B = 1;
  localparam int VGS_MO_CLK_LO_B = 2;
  localparam int VGS_MO_PAGE_B   = 5;
  localparam int VGS_MO_HPOL_B   = 6;
  localparam int VGS_MO_VPOL_B   = 7;
  // feature select and status field positions
  localparam int VGS_FC_VSEL_B   = 3;
  localparam int VGS_S0_SENSE_B  = 4;
  localparam int VGS_S0_IRQ_B    = 7;
  localparam int VGS_S1_DOFF_B   = 0;
  localparam int VGS_S1_VRT_B    = 3;
  localparam int VGS_S1_PIX_LO_B = 4;
  // reset values
  localparam logic [7:0] VGS_MO_RST   = 8'h00;
  localparam logic [7:0] VGS_FC_RST   = 8'h00;
  localparam logic [7:0] VGS_RD_IDLE  = 8'h00;
  // writable bit masks: bit 4 of misc and all but bit 3 of feature reserved
  localparam logic [7:0] VGS_MO_MASK  = 8'hef;
  localparam logic [7:0] VGS_FC_MASK  = 8'h08;
  // pixel clock codes
  localparam logic [1:0] VGS_CLK_640  = 2'h0;
  localparam logic [1:0] VGS_CLK_720  = 2'h1;

  // host i/o request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vgs_io_req_t;

  // decoded configuration outputs
  typedef struct packed {
    logic       colour_addressing_select;
    logic       vram_access_en;
    logic [1:0] pixel_clock_choice;
    logic       clock_reserved;
    logic       aperture_page_even;
    logic       hsync_active_low;
    logic       vsync_active_low;
    logic       vsync_or_de;
  } vgs_cfg_t;

  // whole module state
  typedef struct packed {
    logic [7:0] mo;
    logic [7:0] fc;
    logic [7:0] rdata;
    logic       rvalid;
    logic       vsync;
    logic       hsync;
    logic       page_odd;
  } vgs_state_t;
endpackage : vgs_pkg

// *** vgs_regs.sv ***
/*
  general status and configuration register bank of a vga-compatible
  display controller. host reaches it with single-cycle byte i/o strobes.
  assumes raw syncs, display enable, retrace irq, dac compare and attribute
  pixel outputs arrive synchronous to clk_sys_i.
*/
`timescale 1ns/10ps
`default_nettype none

module vgs_regs (
  input  wire logic                 clk_sys_i,
  input  wire logic                 arst_n_i,
  input  wire vgs_pkg::vgs_io_req_t io_req_i,
  input  wire logic                 vsync_raw_i,
  input  wire logic                 hsync_raw_i,
  input  wire logic                 vdisp_en_i,
  input  wire logic                 display_off_flag_i,
  input  wire logic                 retrace_active_flag_i,
  input  wire logic                 retrace_irq_pending_i,
  input  wire logic                 dac_compare_result_i,
  input  wire logic [7:0]           attr_pixel_i,
  input  wire logic [1:0]           attribute_diag_select_i,
  input  wire logic [7:0]           io_aperture_base_mirror_i,
  input  wire logic                 graphics_chain_i,
  input  wire logic                 sequencer_chain_i,
  input  wire logic                 odd_even_mode_i,
  output logic [7:0]                io_rdata_o,
  output logic                      io_rvalid_o,
  output logic [7:0]                mo_q_o,
  output logic                      vram_access_en_o,
  output logic                      colour_addressing_select_o,
  output logic [1:0]                pixel_clock_choice_o,
  output logic                      page_odd_o,
  output logic                      hsync_o,
  output logic                      vsync_o
);
  import vgs_pkg::*;

  vgs_state_t s_r;      // all state
  vgs_state_t s_nxt;    // next state
  logic       colour;   // current address family
  logic       fc_hit;   // feature/status1 port hit in active family
  logic [1:0] pix_sel;  // attribute pair picked for readback
  logic [7:0] st0;      // input status zero image
  logic [7:0] st1;      // input status one image
  logic       vs_int;   // vsync before polarity

  // one clock and one reset gate every property in this module
  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  assign colour = s_r.mo[VGS_MO_COLOUR_B];

  // only the family named by the addressing bit answers at 3?a
  always_comb begin
    fc_hit = colour ? (io_req_i.addr == VGS_FC_WR_COL_A)
                    : (io_req_i.addr == VGS_FC_WR_MONO_A);
  end

  // attribute pixel pair selection
  always_comb begin
    unique case (attribute_diag_select_i)
      2'h0:    pix_sel = {attr_pixel_i[2], attr_pixel_i[0]};
      2'h1:    pix_sel = {attr_pixel_i[5], attr_pixel_i[4]};
      2'h2:    pix_sel = {attr_pixel_i[3], attr_pixel_i[1]};
      default: pix_sel = {attr_pixel_i[7], attr_pixel_i[6]};
    endcase
  end

  // status images; reserved bits read zero
  always_comb begin
    st0 = VGS_RD_IDLE;
    st0[VGS_S0_SENSE_B] = dac_compare_result_i;
    st0[VGS_S0_IRQ_B]   = retrace_irq_pending_i;
    st1 = VGS_RD_IDLE;
    st1[VGS_S1_DOFF_B]  = display_off_flag_i;
    st1[VGS_S1_VRT_B]   = retrace_active_flag_i;
    st1[VGS_S1_PIX_LO_B +: 2] = pix_sel;
  end

  // sync select: or in display enable when feature bit set
  assign vs_int = s_r.fc[VGS_FC_VSEL_B] ? (vsync_raw_i | vdisp_en_i)
                                        : vsync_raw_i;

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    // write decode
    if (io_req_i.wr) begin
      if (io_req_i.addr == VGS_MO_WR_A) begin
        s_nxt.mo = io_req_i.wdata & VGS_MO_MASK;
      end
      if (fc_hit) begin
        s_nxt.fc = io_req_i.wdata & VGS_FC_MASK;
      end
    end
    // read decode; unmapped reads answer zero
    if (io_req_i.rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = VGS_RD_IDLE;
      if (io_req_i.addr == VGS_MO_RD_A) begin
        s_nxt.rdata = s_r.mo;
      end else if (io_req_i.addr == VGS_MO_WR_A) begin
        s_nxt.rdata = st0;
      end else if (io_req_i.addr == VGS_BASE_RD_A) begin
        s_nxt.rdata = io_aperture_base_mirror_i;
      end else if (io_req_i.addr == VGS_FC_RD_A) begin
        s_nxt.rdata = s_r.fc;
      end else if (fc_hit) begin
        s_nxt.rdata = st1;
      end
    end
    // sync polarity: set bit inverts to active low
    s_nxt.hsync = hsync_raw_i ^ s_r.mo[VGS_MO_HPOL_B];
    s_nxt.vsync = vs_int ^ s_r.mo[VGS_MO_VPOL_B];
    // page bit only counts in plain odd/even, not chain modes
    s_nxt.page_odd = odd_even_mode_i & ~graphics_chain_i &
                     ~sequencer_chain_i &
                     ~s_r.mo[VGS_MO_PAGE_B];
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '{mo: VGS_MO_RST, fc: VGS_FC_RST, rdata: VGS_RD_IDLE,
               rvalid: 1'b0, vsync: 1'b0, hsync: 1'b0, page_odd: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign io_rdata_o                 = s_r.rdata;
  assign io_rvalid_o                = s_r.rvalid;
  assign mo_q_o                     = s_r.mo;
  assign vram_access_en_o           = s_r.mo[VGS_MO_RAM_EN_B];
  assign colour_addressing_select_o = s_r.mo[VGS_MO_COLOUR_B];
  assign pixel_clock_choice_o       = s_r.mo[VGS_MO_CLK_LO_B +: 2];
  assign page_odd_o                 = s_r.page_odd;
  assign hsync_o                    = s_r.hsync;
  assign vsync_o                    = s_r.vsync;

  // misc write lands and reads back next cycle
  property mo_wr_rd_p;
    (io_req_i.wr && io_req_i.addr == VGS_MO_WR_A)
    |=> (mo_q_o == ($past(io_req_i.wdata) & VGS_MO_MASK));
  endproperty
  misc_write_a: assert property (mo_wr_rd_p)
    else $error("misc output not stored");

  // readback port answers with the stored byte; read sees old value
  mo_read_a: assert property (
      (io_req_i.rd && io_req_i.addr == VGS_MO_RD_A)
      |=> io_rvalid_o && io_rdata_o == $past(mo_q_o))
    else $error("misc readback wrong");

  // answer strobe stands one cycle only, never without a read
  rvalid_pulse_a: assert property (
      !io_req_i.rd |=> !io_rvalid_o)
    else $error("read strobe without a read");

  // addressing mode comes from the written byte, not the old register
  colour_mode_a: assert property (
      (io_req_i.wr && io_req_i.addr == VGS_MO_WR_A)
      |=> colour_addressing_select_o ==
          $past(io_req_i.wdata[VGS_MO_COLOUR_B]))
    else $error("addressing mode not taken");

  // video ram gate follows the written byte
  ram_gate_a: assert property (
      (io_req_i.wr && io_req_i.addr == VGS_MO_WR_A)
      |=> vram_access_en_o == $past(io_req_i.wdata[VGS_MO_RAM_EN_B]))
    else $error("ram gate mismatch");

  // pixel clock code passes through, reserved codes too
  clock_pick_a: assert property (
      (io_req_i.wr && io_req_i.addr == VGS_MO_WR_A)
      |=> pixel_clock_choice_o ==
          $past(io_req_i.wdata[VGS_MO_CLK_LO_B +: 2]))
    else $error("pixel clock code not taken");

  // plain odd/even: a clear page bit selects the odd page
  page_pick_a: assert property (
      (odd_even_mode_i && !graphics_chain_i && !sequencer_chain_i)
      |=> page_odd_o == !$past(mo_q_o[VGS_MO_PAGE_B]))
    else $error("odd/even page wrong");

  // chained or non odd/even modes never pick the odd page
  chain_page_a: assert property (
      (!odd_even_mode_i || graphics_chain_i || sequencer_chain_i)
      |=> !page_odd_o)
    else $error("page bit used outside plain odd/even");

  // hsync is the raw pulse, inverted when the polarity bit is set
  hsync_pol_a: assert property (
      $stable(mo_q_o) |=> hsync_o == ($past(hsync_raw_i)
                                      ^ $past(mo_q_o[VGS_MO_HPOL_B])))
    else $error("hsync polarity wrong");

  // active-low vsync idles high between pulses
  vsync_pol_a: assert property (
      (!s_r.fc[VGS_FC_VSEL_B] && !vsync_raw_i && mo_q_o[VGS_MO_VPOL_B])
      |=> vsync_o)
    else $error("vsync polarity wrong");

  // feature bit ors display enable into the vertical pulse
  vsync_or_a: assert property (
      (s_r.fc[VGS_FC_VSEL_B] && vdisp_en_i && !mo_q_o[VGS_MO_VPOL_B])
      |=> vsync_o)
    else $error("vsync not ored with display enable");

  // feature write in the active family stores the select bit
  fc_write_a: assert property (
      (io_req_i.wr && fc_hit)
      |=> s_r.fc[VGS_FC_VSEL_B] == $past(io_req_i.wdata[VGS_FC_VSEL_B]))
    else $error("feature select not stored");

  // status zero carries the pending interrupt and the comparator
  irq_read_a: assert property (
      (io_req_i.rd && io_req_i.addr == VGS_MO_WR_A)
      |=> io_rdata_o[VGS_S0_IRQ_B] == $past(retrace_irq_pending_i) &&
          io_rdata_o[VGS_S0_SENSE_B] == $past(dac_compare_result_i))
    else $error("status zero wrong");

  // status one carries display-off and retrace flags
  st1_read_a: assert property (
      (io_req_i.rd && fc_hit)
      |=> io_rdata_o[VGS_S1_VRT_B] == $past(retrace_active_flag_i) &&
          io_rdata_o[VGS_S1_DOFF_B] == $past(display_off_flag_i))
    else $error("status one wrong");

  // select 1 returns pixels 5 and 4 in place
  pix_mid_a: assert property (
      (io_req_i.rd && fc_hit && attribute_diag_select_i == 2'h1)
      |=> io_rdata_o[VGS_S1_PIX_LO_B +: 2] == $past(attr_pixel_i[5:4]))
    else $error("pixel pair one wrong");

  // select 3 returns pixels 7 and 6 in bits 5 and 4
  pix_hi_a: assert property (
      (io_req_i.rd && fc_hit && attribute_diag_select_i == 2'h3)
      |=> io_rdata_o[VGS_S1_PIX_LO_B +: 2] == $past(attr_pixel_i[7:6]))
    else $error("pixel pair three wrong");

  // base port mirrors the aperture base input
  base_read_a: assert property (
      (io_req_i.rd && io_req_i.addr == VGS_BASE_RD_A)
      |=> io_rdata_o == $past(io_aperture_base_mirror_i))
    else $error("base mirror wrong");

  // feature read port returns the select bit alone, reserved bits zero
  fc_read_a: assert property (
      (io_req_i.rd && io_req_i.addr == VGS_FC_RD_A)
      |=> io_rdata_o[VGS_FC_VSEL_B] == $past(s_r.fc[VGS_FC_VSEL_B]) &&
          (io_rdata_o & ~VGS_FC_MASK) == VGS_RD_IDLE)
    else $error("feature readback wrong");

  // feature writes from the other family leave the register alone
  alias_block_a: assert property (
      (io_req_i.wr && !io_req_i.rd && !fc_hit &&
       io_req_i.addr != VGS_MO_WR_A) |=> $stable(s_r.fc))
    else $error("feature written from wrong family");

  // status one port of the other family reads zero
  st1_family_a: assert property (
      (io_req_i.rd && !fc_hit &&
       (io_req_i.addr == VGS_FC_WR_MONO_A ||
        io_req_i.addr == VGS_FC_WR_COL_A))
      |=> io_rdata_o == VGS_RD_IDLE)
    else $error("status one answered from wrong family");

  // main scenarios
  cov_mo_wr_c: cover property (io_req_i.wr && io_req_i.addr == VGS_MO_WR_A);
  cov_col_fc_c: cover property (io_req_i.wr && fc_hit && colour);
  cov_st1_c: cover property (io_req_i.rd && fc_hit);
  cov_page_c: cover property (page_odd_o);
  cov_vs_or_c: cover property (s_r.fc[VGS_FC_VSEL_B] && vdisp_en_i);
endmodule : vgs_regs

`default_nettype wire

// *** vgs_host_model.sv ***
/*
  host model: drives single-cycle byte i/o strobes at the bank.
  assumes one clock; requests launch 1 ns after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module vgs_host_model (
  input  wire logic                 clk_sys_i,
  input  wire logic [7:0]           io_rdata_i,
  input  wire logic                 io_rvalid_i,
  output var  vgs_pkg::vgs_io_req_t io_req_o
);
  import vgs_pkg::*;
  // idle bus shows inverted last values, so stale copies never match
  initial io_req_o = '0;
  // write strobe stands exactly one cycle
  task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    #1 io_req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge clk_sys_i);
    #1 io_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
  endtask : io_wr
  // read strobe; answer stands one cycle after the taking edge
  task automatic io_rd(input logic [15:0] a, output logic [7:0] v,
                       output logic ok);
    @(posedge clk_sys_i);
    #1 io_req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    #1 ok = io_rvalid_i;
    v  = io_rdata_i;
    io_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
  endtask : io_rd
endmodule : vgs_host_model
`default_nettype wire

// *** vga_general_status_config_test.sv ***
/*
  self-checking bench for the status and configuration bank.
  assumes vgs_regs and vgs_host_model; 100 mhz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_vga_general_status_config;
  import vgs_pkg::*;
  logic        clk_sys_i = 1'b0;  // system clock
  logic        arst_n_i  = 1'b0;  // reset, active low
  vgs_io_req_t req;               // host request
  logic        hs_raw = 0, vs_raw = 0, vde = 0, doff = 0, vrt = 0;
  logic        irq = 0, dac = 0, gch = 0, sch = 0, oe = 0;
  logic [7:0]  pix = '0, base = '0, rdata, mo_q, d;
  logic [1:0]  asel = '0, clk_sel;
  logic        rvalid, ram_en, colour, page_odd, hs, vs, ok;
  int          error_cnt = 0, checked = 0, s, b;
  int          hi [4] = '{2, 5, 3, 7};  // pair bit 5 per select
  int          lo [4] = '{0, 4, 1, 6};  // pair bit 4 per select

  vgs_host_model u_host (.clk_sys_i(clk_sys_i), .io_rdata_i(rdata),
    .io_rvalid_i(rvalid), .io_req_o(req));
  vgs_regs u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .io_req_i(req), .vsync_raw_i(vs_raw), .hsync_raw_i(hs_raw),
    .vdisp_en_i(vde), .display_off_flag_i(doff),
    .retrace_active_flag_i(vrt), .retrace_irq_pending_i(irq),
    .dac_compare_result_i(dac), .attr_pixel_i(pix),
    .attribute_diag_select_i(asel), .io_aperture_base_mirror_i(base),
    .graphics_chain_i(gch), .sequencer_chain_i(sch),
    .odd_even_mode_i(oe), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
    .mo_q_o(mo_q), .vram_access_en_o(ram_en),
    .colour_addressing_select_o(colour),
    .pixel_clock_choice_o(clk_sel), .page_odd_o(page_odd),
    .hsync_o(hs), .vsync_o(vs));

  // free-running clock
  initial forever #5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // a missing answer strobe turns into a data mismatch
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    u_host.io_rd(a, d, ok);
    chk((ok === 1'b1) ? d : ~e, e);
  endtask : rd_chk
  // registered outputs lag one cycle; two edges leave margin
  task automatic settle;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : settle
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // whole run takes about a microsecond; cut a hang well after
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 arst_n_i = 1'b1;
    rd_chk(VGS_MO_RD_A, 8'h00);
    rd_chk(VGS_FC_RD_A, 8'h00);
    u_host.io_wr(VGS_MO_WR_A, 8'hff);
    chk(mo_q, 8'hef);
    rd_chk(VGS_MO_RD_A, 8'hef);
    // every clock code, with mode and ram bits alternating
    for (s = 0; s < 4; s++) begin
      u_host.io_wr(VGS_MO_WR_A, {4'h0, 2'(s), s[0], ~s[0]});
      settle();
      chk({4'h0, colour, ram_en, clk_sel}, {4'h0, ~s[0], s[0], 2'(s)});
    end
    $display("test misc done");
    u_host.io_wr(VGS_MO_WR_A, 8'h01);
    hs_raw = 1'b1;
    vs_raw = 1'b1;
    settle();
    chk({6'h00, hs, vs}, 8'h03);
    u_host.io_wr(VGS_MO_WR_A, 8'hc1);
    settle();
    chk({6'h00, hs, vs}, 8'h00);
    hs_raw = 1'b0;
    vs_raw = 1'b0;
    vde = 1'b1;
    settle();
    chk({6'h00, hs, vs}, 8'h03);
    u_host.io_wr(VGS_FC_WR_COL_A, 8'hff);
    settle();
    chk({7'h00, vs}, 8'h00);
    rd_chk(VGS_FC_RD_A, 8'h08);
    u_host.io_wr(VGS_FC_WR_MONO_A, 8'h00);
    rd_chk(VGS_FC_RD_A, 8'h08);
    $display("test sync done");
    // plain odd/even page, then each chain overriding
    oe = 1'b1;
    settle();
    chk({7'h00, page_odd}, 8'h01);
    gch = 1'b1;
    settle();
    chk({7'h00, page_odd}, 8'h00);
    {gch, sch} = 2'b01;
    settle();
    chk({7'h00, page_odd}, 8'h00);
    sch = 1'b0;
    u_host.io_wr(VGS_MO_WR_A, 8'h21);
    settle();
    chk({7'h00, page_odd}, 8'h00);
    // status one: each select, each pixel of the pair alone
    {doff, vrt} = 2'b11;
    for (s = 0; s < 4; s++) begin
      for (b = 0; b < 2; b++) begin
        asel = 2'(s);
        pix = 8'h01 << (b ? hi[s] : lo[s]);
        rd_chk(VGS_FC_WR_COL_A, {2'b00, b[0], ~b[0], 4'h9});
      end
    end
    rd_chk(VGS_FC_WR_MONO_A, 8'h00);
    {irq, dac} = 2'b10;
    rd_chk(VGS_MO_WR_A, 8'h80);
    {irq, dac} = 2'b01;
    rd_chk(VGS_MO_WR_A, 8'h10);
    base = 8'ha5;
    rd_chk(VGS_BASE_RD_A, 8'ha5);
    rd_chk(16'h03c0, 8'h00);
    $display("test status done");
    // mono family: 3da dropped, 3ba taken
    u_host.io_wr(VGS_MO_WR_A, 8'h00);
    u_host.io_wr(VGS_FC_WR_COL_A, 8'h00);
    rd_chk(VGS_FC_RD_A, 8'h08);
    u_host.io_wr(VGS_FC_WR_MONO_A, 8'h00);
    rd_chk(VGS_FC_RD_A, 8'h00);
    rd_chk(VGS_FC_WR_COL_A, 8'h00);
    $display("test mono done");
    // mid-run reset must clear settings stored just before it
    u_host.io_wr(VGS_MO_WR_A, 8'he3);
    u_host.io_wr(VGS_FC_WR_COL_A, 8'h08);
    rd_chk(VGS_FC_RD_A, 8'h08);
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 arst_n_i = 1'b1;
    chk(mo_q, 8'h00);
    rd_chk(VGS_MO_RD_A, 8'h00);
    rd_chk(VGS_FC_RD_A, 8'h00);
    $display("test reset done");
    close_out();
  end
endmodule : test_vga_general_status_config
`default_nettype wire
